/* File: design/irf_req_combine.v */
// Per-bit polarity, enable masking and output polarity for the flag vector
`timescale 1ns/1ps
`include "irf_regs.vh"

module irf_req_combine #(
  parameter W = 16
) (
  // Flag state and settings
  input  wire [W-1:0] flags,
  input  wire [W-1:0] polarity,
  input  wire [W-1:0] intEnable,
  input  wire [W-1:0] extEnable,
  input  wire         intInvert,
  input  wire         extInvert,
  // Combined requests
  output wire [W-1:0] bitReq,
  output wire         intReq,
  output wire         extReq
);

  // Each bit requests when flag and polarity differ
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : gBit
      assign bitReq[i] = flags[i] ^ polarity[i];
    end
  endgenerate

  // Enabled requests are ORed, then polarity-adjusted
  assign intReq = (|(bitReq & intEnable)) ^ intInvert;
  assign extReq = (|(bitReq & extEnable)) ^ extInvert;

endmodule

/* File: design/irf_request_flags.v */
// Software interrupt request flag block with AXI4-Lite register slave
//
// Notes on behaviour
// - One 16-bit flag vector, reset zero, seen at direct and set/clear addresses.
// - Core write to set/clear alias sets flags where data bits are one.
// - Other master write to set/clear alias clears flags where data is one.
// - Write to the direct alias loads the bits of each strobed byte lane as written.
// - Per-bit request is flag XOR per-bit polarity; polarity resets zero.
// - Control bit 2 picks pin driver: zero open drain, one totem pole.
// - Control bit 1, reset one, inverts the external request.
// - Control bit 0, reset one, inverts the internal request.
// - Internal enable mask, reset zero, gates each request to internal cause.
// - External enable mask, reset zero, gates each request to external pin.
`timescale 1ns/1ps
`include "irf_regs.vh"

module irf_request_flags #(
  parameter W = 16
) (
  // Clock and reset
  input  wire        clk,
  input  wire        arst_n,
  // Master identity: high when the core issues the write
  input  wire        wrFromCore,
  // AXI4-Lite write address
  input  wire [15:0] s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [15:0] s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Requests
  output reg         intRequest,
  output reg         extPinOut,
  output reg         extPinOe,
  output reg         irqOut
);

  // Register state
  reg [W-1:0]            flags_q;
  reg [W-1:0]            polarity_q;
  reg [`IRF_CTL_W-1:0]   control_q;
  reg [W-1:0]            intEn_q;
  reg [W-1:0]            extEn_q;
  reg [`IRF_EVT_W-1:0]   evtStat_q;
  reg [`IRF_EVT_W-1:0]   evtMask_q;
  // Request level history for the event detectors
  reg                    intReqPrev_q;
  reg                    extReqPrev_q;

  // Write channel capture
  reg [15:0]             awAddr_q;
  reg                    awHave_q;
  reg [31:0]             wData_q;
  reg [3:0]              wStrb_q;
  reg                    wHave_q;
  reg                    wCore_q;

  wire [W-1:0]           bitReq;
  wire                   intReq;
  wire                   extReq;

  // Request combining network
  irf_req_combine #(
    .W (W)
  ) uCombine (
    .flags     (flags_q),
    .polarity  (polarity_q),
    .intEnable (intEn_q),
    .extEnable (extEn_q),
    .intInvert (control_q[`IRF_CTL_INTERNAL_POLARITY_INVERT]),
    .extInvert (control_q[`IRF_CTL_EXTERNAL_POLARITY_INVERT]),
    .bitReq    (bitReq),
    .intReq    (intReq),
    .extReq    (extReq)
  );

  // Write completes once both address and data are held
  // Holding the response stalls further writes: one write is in flight
  wire doWrite = awHave_q && wHave_q && !s_axi_bvalid;

  // Byte-lane expansion of the strobes for the low half-word
  wire [W-1:0] laneMask = {{8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
  wire [W-1:0] wBits    = wData_q[W-1:0] & laneMask;

  wire wrDirect = doWrite && (awAddr_q == `IRF_OFS_DIRECT);
  wire wrSetClr = doWrite && (awAddr_q == `IRF_OFS_SETCLR);
  wire wrKnown  = (awAddr_q == `IRF_OFS_DIRECT)   ||
                  (awAddr_q == `IRF_OFS_SETCLR)   ||
                  (awAddr_q == `IRF_OFS_POLARITY) ||
                  (awAddr_q == `IRF_OFS_CONTROL)  ||
                  (awAddr_q == `IRF_OFS_INT_EN)   ||
                  (awAddr_q == `IRF_OFS_EXT_EN)   ||
                  (awAddr_q == `IRF_OFS_EVT_STAT) ||
                  (awAddr_q == `IRF_OFS_EVT_MASK);

  // Next flag value; one storage behind both aliases
  // Direct alias wins; both aliases can never be addressed at once
  reg [W-1:0] flags_d;
  always @* begin
    flags_d = flags_q;
    if (wrDirect) begin
      flags_d = (flags_q & ~laneMask) | wBits;
    end else if (wrSetClr && wCore_q) begin
      flags_d = flags_q | wBits;
    end else if (wrSetClr) begin
      flags_d = flags_q & ~wBits;
    end
  end

  // Events: rising edges of the internal and external request levels
  // History is compared with the combined level, not the registered pins
  wire [`IRF_EVT_W-1:0] evtNow = {extReq & ~extReqPrev_q,
                                  intReq & ~intReqPrev_q};
  wire [`IRF_EVT_W-1:0] evtClr =
    (doWrite && awAddr_q == `IRF_OFS_EVT_STAT && wStrb_q[0]) ?
    wData_q[`IRF_EVT_W-1:0] : {`IRF_EVT_W{1'b0}};

  // Write channel acceptance, either order
  // Each ready pulses for one cycle; a second request is taken once the
  // pending write is done, but is not written until the response has drained
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awHave_q      <= 1'b0;
      wHave_q       <= 1'b0;
      awAddr_q      <= 16'h0000;
      wData_q       <= 32'h0000_0000;
      wStrb_q       <= 4'h0;
      wCore_q       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `IRF_RESP_OKAY;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      if (s_axi_awvalid && !awHave_q && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        awHave_q      <= 1'b1;
        awAddr_q      <= {s_axi_awaddr[15:2], 2'b00};
        wCore_q       <= wrFromCore; // Identity sampled with the address
      end
      if (s_axi_wvalid && !wHave_q && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        wHave_q      <= 1'b1;
        wData_q      <= s_axi_wdata;
        wStrb_q      <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHave_q     <= 1'b0;
        wHave_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrKnown ? `IRF_RESP_OKAY : `IRF_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Write selects, one per register
  wire wrPolarity = doWrite && (awAddr_q == `IRF_OFS_POLARITY);
  wire wrControl  = doWrite && (awAddr_q == `IRF_OFS_CONTROL) && wStrb_q[0];
  wire wrIntEn    = doWrite && (awAddr_q == `IRF_OFS_INT_EN);
  wire wrExtEn    = doWrite && (awAddr_q == `IRF_OFS_EXT_EN);
  wire wrEvtMask  = doWrite && (awAddr_q == `IRF_OFS_EVT_MASK) && wStrb_q[0];

  // Flag storage, edge history and sticky event status
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q      <= `IRF_RST_FLAGS;
      // History starts at the idle level the reset control bits give,
      // so leaving reset does not look like a request edge
      intReqPrev_q <= 1'b1;
      extReqPrev_q <= 1'b1;
      evtStat_q    <= {`IRF_EVT_W{1'b0}};
    end else begin
      flags_q      <= flags_d;
      intReqPrev_q <= intReq;
      extReqPrev_q <= extReq;
      // Set wins over a simultaneous write-one clear
      evtStat_q    <= (evtStat_q & ~evtClr) | evtNow;
    end
  end

  // Polarity and enable masks; strobes honoured per byte lane
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      polarity_q <= `IRF_RST_POL;
      intEn_q    <= `IRF_RST_MASK;
      extEn_q    <= `IRF_RST_MASK;
    end else begin
      if (wrPolarity) begin
        polarity_q <= (polarity_q & ~laneMask) | wBits;
      end
      if (wrIntEn) begin
        intEn_q <= (intEn_q & ~laneMask) | wBits;
      end
      if (wrExtEn) begin
        extEn_q <= (extEn_q & ~laneMask) | wBits;
      end
    end
  end

  // Control and event mask take only the low byte lane
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      control_q <= `IRF_RST_CTL;
      evtMask_q <= {`IRF_EVT_W{1'b0}};
    end else begin
      if (wrControl) begin
        control_q <= wData_q[`IRF_CTL_W-1:0];
      end
      if (wrEvtMask) begin
        evtMask_q <= wData_q[`IRF_EVT_W-1:0];
      end
    end
  end

  // Read mux; reserved bits read zero
  // Decoded from the live address so data is ready at acceptance
  reg [31:0] rdMux;
  reg        rdKnown;
  always @* begin
    rdMux   = 32'h0000_0000;
    rdKnown = 1'b1;
    case ({s_axi_araddr[15:2], 2'b00})
      `IRF_OFS_DIRECT:   rdMux[W-1:0] = flags_q;
      `IRF_OFS_SETCLR:   rdMux[W-1:0] = flags_q;
      `IRF_OFS_POLARITY: rdMux[W-1:0] = polarity_q;
      `IRF_OFS_CONTROL:  rdMux[`IRF_CTL_W-1:0] = control_q;
      `IRF_OFS_INT_EN:   rdMux[W-1:0] = intEn_q;
      `IRF_OFS_EXT_EN:   rdMux[W-1:0] = extEn_q;
      `IRF_OFS_EVT_STAT: rdMux[`IRF_EVT_W-1:0] = evtStat_q;
      `IRF_OFS_EVT_MASK: rdMux[`IRF_EVT_W-1:0] = evtMask_q;
      default:           rdKnown = 1'b0;
    endcase
  end

  // Read channel: one read at a time, answer raised in the same cycle as arready
  // Data is captured at acceptance, so a slow rready cannot see a later
  // register change
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `IRF_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdMux;
        s_axi_rresp   <= rdKnown ? `IRF_RESP_OKAY : `IRF_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Output stage: registered so no glitch reaches the pin or the core.
  // Open drain only pulls low; a high level needs the external pull-up.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      intRequest <= 1'b0;
      extPinOut  <= 1'b0;
      extPinOe   <= 1'b0;
      irqOut     <= 1'b0;
    end else begin
      intRequest <= intReq;
      extPinOut  <= extReq;
      // Open drain mode enables the driver only while the request is low
      if (control_q[`IRF_CTL_DRIVE]) begin
        extPinOe <= 1'b1;
      end else begin
        extPinOe <= ~extReq;
      end
      // Event interrupt follows the sticky status through its mask
      irqOut <= |(evtStat_q & evtMask_q);
    end
  end

  // Protection bits carry no meaning here
  wire unusedProt = ^{s_axi_awprot, s_axi_arprot, bitReq,
                      wData_q[31:W], wStrb_q[3:2]};

endmodule

/* File: pkg/irf_regs.vh */
// Register offsets, field positions, reset values for request flag block
`ifndef IRF_REGS_VH
`define IRF_REGS_VH

`define IRF_ADDR_W        16
`define IRF_OFS_DIRECT    16'hf510
`define IRF_OFS_SETCLR    16'hf514
`define IRF_OFS_POLARITY  16'hf518
`define IRF_OFS_CONTROL   16'hf51c
`define IRF_OFS_INT_EN    16'hf520
`define IRF_OFS_EXT_EN    16'hf524
`define IRF_OFS_EVT_STAT  16'hf528
`define IRF_OFS_EVT_MASK  16'hf52c

`define IRF_FLAG_W        16
`define IRF_CTL_W         3
`define IRF_CTL_DRIVE     2
`define IRF_CTL_EXTERNAL_POLARITY_INVERT    1
`define IRF_CTL_INTERNAL_POLARITY_INVERT    0
`define IRF_RST_FLAGS     16'h0000
`define IRF_RST_POL       16'h0000
`define IRF_RST_CTL       3'h3
`define IRF_RST_MASK      16'h0000
`define IRF_EVT_W         2
`define IRF_RESP_OKAY     2'h0
`define IRF_RESP_SLVERR   2'h2

`endif

/* File: verif/irf_bus_master.sv */
// Bus master model standing for the core and the other masters
`timescale 1ns/1ps
module irf_bus_master (
  // Clock
  input  logic        clk,
  // Identity and write side
  output logic        wrFromCore,
  output logic [15:0] s_axi_awaddr,
  output logic [2:0]  s_axi_awprot,
  output logic        s_axi_awvalid,
  input  logic        s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  output logic        s_axi_wvalid,
  input  logic        s_axi_wready,
  input  logic [1:0]  s_axi_bresp,
  input  logic        s_axi_bvalid,
  output logic        s_axi_bready,
  // Read side
  output logic [15:0] s_axi_araddr,
  output logic [2:0]  s_axi_arprot,
  output logic        s_axi_arvalid,
  input  logic        s_axi_arready,
  input  logic [31:0] s_axi_rdata,
  input  logic [1:0]  s_axi_rresp,
  input  logic        s_axi_rvalid,
  output logic        s_axi_rready
);
  // Full strobes: every register is one whole word
  initial begin
    {wrFromCore, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
    {s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 10'h00f;
    {s_axi_bready, s_axi_rready} = 2'h2;
  end
  // Write: both halves offered together, each scrambled once taken
  task automatic wr(input logic [15:0] a, input logic [31:0] d,
                    input logic core, output logic [1:0] r);
    {s_axi_awaddr, s_axi_wdata, wrFromCore} <= {a, d, core};
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    do begin
      @(posedge clk);
      if (s_axi_awready) {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (s_axi_wready) {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  // Read: rready held back one cycle so the slave must keep its answer
  task automatic rd(input logic [15:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    do begin
      @(posedge clk);
      if (s_axi_arready) {s_axi_arvalid, s_axi_araddr, s_axi_rready} <=
        {1'b0, ~a, 1'b1};
    end while (!(s_axi_rvalid && s_axi_rready));
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
endmodule

/* File: verif/irf_request_flags_props.sv */
// Checker for the request flag block, bound to its top module
`timescale 1ns/1ps
`include "irf_regs.vh"
module irf_request_flags_props (
  // Clock and reset
  input logic        clk,
  input logic        arst_n,
  // Bus handshakes
  input logic        s_axi_awvalid,
  input logic        s_axi_bvalid,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  // Requests
  input logic        intRequest,
  input logic        extPinOut,
  input logic        extPinOe,
  input logic        irqOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_rd_answer: assert property (s_axi_arvalid && !s_axi_arready &&
    !s_axi_rvalid |=> s_axi_rvalid) else $error("read not answered");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data lost");
  a_wr_answer: assert property ($rose(s_axi_awvalid) |-> ##[1:6]
    s_axi_bvalid) else $error("write not answered");
  a_err_data_zero: assert property (s_axi_rvalid && s_axi_rresp ==
    `IRF_RESP_SLVERR |-> s_axi_rdata == 32'h0) else $error("err data");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] ==
    16'h0) else $error("upper bits set");
  a_od_release: assert property ($past(arst_n) && !extPinOe |-> extPinOut)
    else $error("pin released while low");
  a_int_quiet: assert property ($changed(intRequest) |-> $past(s_axi_bvalid)
    || $past(s_axi_bvalid, 2) || !$past(arst_n, 2))
    else $error("internal request moved alone");
  a_ext_quiet: assert property ($changed(extPinOut) |-> $past(s_axi_bvalid)
    || $past(s_axi_bvalid, 2) || !$past(arst_n, 2))
    else $error("external request moved alone");
  // Main scenarios seen
  c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == `IRF_RESP_SLVERR);
  c_irq: cover property ($rose(irqOut));
  c_pin_low: cover property ($rose(extPinOe) && !extPinOut);
endmodule
bind irf_request_flags irf_request_flags_props i_irf_request_flags_props (
  .clk, .arst_n, .s_axi_awvalid, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .intRequest, .extPinOut, .extPinOe, .irqOut);

/* File: verif/irf_request_flags_tb.sv */
// Self-checking bench for the request flag block
`timescale 1ns/1ps
`include "irf_regs.vh"
`define CHK(a, e) begin checkCount++; if ((a) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module irf_request_flags_tb;
  logic clk, arst_n, wrFromCore, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic intRequest, extPinOut, extPinOe, irqOut;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int failures = 0, checkCount = 0, cyc = 0;
  irf_request_flags i_irf_request_flags (.*);
  irf_bus_master i_irf_bus_master (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_sim();
    $display("failures=%0d checks=%0d", failures, checkCount);
    if (failures == 0 && checkCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Write, compare response; outputs lag the register by a cycle
  task automatic w(input logic [15:0] a, input logic [31:0] d,
                   input logic core = 1'b1, input logic [1:0] er = 2'h0);
    logic [1:0] r;
    i_irf_bus_master.wr(a, d, core, r);
    `CHK(r, er)
    repeat (2) @(posedge clk);
  endtask
  task automatic rc(input logic [15:0] a, input logic [31:0] e,
                    input logic [1:0] er = 2'h0);
    logic [31:0] d;
    logic [1:0] r;
    i_irf_bus_master.rd(a, d, r);
    `CHK({r, d}, {er, e})
  endtask
  // Hang guard, far above the length of the sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    arst_n = 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    `CHK({intRequest, extPinOut, extPinOe}, 3'h6)
    rc(`IRF_OFS_SETCLR, 32'h0);
    rc(`IRF_OFS_POLARITY, 32'h0);
    rc(`IRF_OFS_CONTROL, 32'h3);
    rc(`IRF_OFS_INT_EN, 32'h0);
    rc(`IRF_OFS_EXT_EN, 32'h0);
    rc(`IRF_OFS_EVT_STAT, 32'h0);
    w(`IRF_OFS_DIRECT, 32'ha5c3);
    rc(`IRF_OFS_SETCLR, 32'ha5c3);
    w(`IRF_OFS_SETCLR, 32'h0f00);
    rc(`IRF_OFS_DIRECT, 32'hafc3);
    w(`IRF_OFS_SETCLR, 32'h00c3, 1'b0);
    rc(`IRF_OFS_DIRECT, 32'haf00);
    w(16'hf530, 32'hffff, 1'b1, `IRF_RESP_SLVERR);
    rc(16'hf530, 32'h0, `IRF_RESP_SLVERR);
    rc(`IRF_OFS_SETCLR, 32'haf00);
    w(`IRF_OFS_CONTROL, 32'h0);
    w(`IRF_OFS_EVT_STAT, 32'h3);
    w(`IRF_OFS_EVT_MASK, 32'h1);
    `CHK({intRequest, extPinOut, extPinOe, irqOut}, 4'h2)
    w(`IRF_OFS_INT_EN, 32'h1);
    w(`IRF_OFS_POLARITY, 32'hffffffff);
    rc(`IRF_OFS_POLARITY, 32'hffff);
    `CHK({intRequest, extPinOut, irqOut}, 3'h5)
    w(`IRF_OFS_EVT_MASK, 32'h0);
    `CHK(irqOut, 1'b0)
    w(`IRF_OFS_EVT_MASK, 32'h1);
    w(`IRF_OFS_EVT_STAT, 32'h1);
    `CHK(irqOut, 1'b0)
    w(`IRF_OFS_INT_EN, 32'h100);
    `CHK(intRequest, 1'b0)
    w(`IRF_OFS_EXT_EN, 32'h1);
    `CHK({extPinOut, extPinOe}, 2'h2)
    w(`IRF_OFS_CONTROL, 32'h6);
    `CHK({extPinOut, extPinOe}, 2'h1)
    w(`IRF_OFS_CONTROL, 32'h5);
    `CHK({intRequest, extPinOut, extPinOe}, 3'h7)
    end_sim();
  end
endmodule
